// [rtl/dual_channel_dac_control.sv]
// APB register block and converter drive logic for a two-channel 8-bit DAC
//
// Function
// [RL1] Two 8-bit readable and writable code registers hold one code per channel.
// [RL2] Both code registers clear to zero on reset and on entry to standby.
// [RL3] With the standby output enable set, code and control registers survive software standby.
// [RL4] An enabled channel continuously presents its stored code to the converter.
// [RL5] The control register becomes 1F hex on reset and on entry to standby.
// [RL6] Control bit 7 disables channel 1 output at 0 and enables its conversion and output at 1.
// [RL7] Control bit 6 disables channel 0 output at 0 and enables its conversion and output at 1.
// [RL8] Control bit 5 makes conversion per channel at 0 and joint for both channels at 1.
// [RL9] No channel converts with both enables low; both convert with both high, or one and joint.
// [RL10] Each analog output drive follows only its own output enable bit.
// [RL11] Reserved control bits 4..0 and standby bits 7..1 ignore writes and read as one.
// [RL12] The standby register becomes FE hex on reset and in hardware standby, kept in software.
// [RL13] Standby bit 0 at 0 cuts the output in software standby, at 1 keeps it driven.
// [RL14] A rewritten code is presented to the converter at once while the channel converts.
// [RL15] Per channel one conversion enable, one output enable and the 8-bit code go to the macro.
//
// The APB register port is this design's own decision.
`default_nettype none
module dual_channel_dac_control (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dac_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // Power modes from the system controller
    input wire logic sw_standby,
    input wire logic hw_standby,
    // Converter macro
    output var dac_ctrl_pkg::dac_drive_t drive
);

    // One control field placed at its bit position in a read byte
    function automatic logic [7:0] place_bit(input logic value, input int pos);
        logic [7:0] word;
        word = 8'h00;
        word[pos] = value;
        return word;
    endfunction : place_bit

    // Conversion enable of one channel: its own enable, or joint mode with the other's
    function automatic logic conv_enable(input logic own_oe, input logic other_oe,
        input logic joint);
        conv_enable = own_oe | (joint & other_oe);
    endfunction : conv_enable

    // Power mode seen last cycle; run to either standby flips one bit
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SOFT = 2'b01,
        MODE_HARD = 2'b10
    } power_mode_t;

    power_mode_t mode_r;
    power_mode_t mode_nxt;

    logic [7:0] channel0_code_r;
    logic [7:0] channel1_code_r;
    logic channel0_output_enable_r;
    logic channel1_output_enable_r;
    logic joint_conversion_enable_r;
    logic standby_output_enable_r;
    logic wr_data0;
    logic wr_data1;
    logic wr_ctrl;
    logic wr_stby;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    dac_ctrl_pkg::dac_drive_t drive_r;
    dac_ctrl_pkg::dac_drive_t drive_nxt;

    logic [dac_ctrl_pkg::IDX_W-1:0] idx;
    logic hit_data0;
    logic hit_data1;
    logic hit_ctrl;
    logic hit_stby;
    logic hit_any;
    logic wr_fire;
    logic sw_entry;
    logic conv_reinit;
    logic [7:0] ctrl_view;
    logic [7:0] stby_view;
    logic [7:0] rd_byte;

    // Address decode
    assign idx = dac_ctrl_pkg::reg_index(paddr);
    assign hit_data0 = (idx == dac_ctrl_pkg::IDX_DATA0);
    assign hit_data1 = (idx == dac_ctrl_pkg::IDX_DATA1);
    assign hit_ctrl = (idx == dac_ctrl_pkg::IDX_CTRL);
    assign hit_stby = (idx == dac_ctrl_pkg::IDX_STBY);
    assign hit_any = hit_data0 | hit_data1 | hit_ctrl | hit_stby;

    // Write lands only on the access edge where ready is seen; ignored in hardware standby
    assign wr_fire = psel & penable & pready_r & pwrite & hit_any & ~hw_standby;

    // One write strobe per register, so each register block stays a plain priority chain
    assign wr_data0 = wr_fire & hit_data0;
    assign wr_data1 = wr_fire & hit_data1;
    assign wr_ctrl = wr_fire & hit_ctrl;
    assign wr_stby = wr_fire & hit_stby;

    // Software standby entry, seen once per stay; leaving hardware standby with
    // software standby still high counts as a fresh entry
    always_comb begin
        sw_entry = 1'b0;
        unique case (mode_r)
            MODE_RUN: begin
                sw_entry = sw_standby & ~hw_standby;
            end
            MODE_SOFT: begin
                sw_entry = 1'b0;
            end
            MODE_HARD: begin
                sw_entry = sw_standby & ~hw_standby;
            end
            default: begin
                sw_entry = sw_standby & ~hw_standby;
            end
        endcase
    end

    // Reinitialise unless the output is kept alive through software standby
    assign conv_reinit = hw_standby | (sw_entry & ~standby_output_enable_r); // RL3

    // Read views with reserved bits forced high
    assign ctrl_view = dac_ctrl_pkg::CTRL_RSVD
        | place_bit(channel1_output_enable_r, dac_ctrl_pkg::CTRL_OE1_BIT)
        | place_bit(channel0_output_enable_r, dac_ctrl_pkg::CTRL_OE0_BIT)
        | place_bit(joint_conversion_enable_r, dac_ctrl_pkg::CTRL_JOINT_BIT); // RL11
    assign stby_view = dac_ctrl_pkg::STBY_RSVD
        | place_bit(standby_output_enable_r, dac_ctrl_pkg::STBY_OE_BIT); // RL11

    // Read mux
    always_comb begin
        rd_byte = 8'h00;
        if (hit_data0) begin
            rd_byte = channel0_code_r;
        end else if (hit_data1) begin
            rd_byte = channel1_code_r;
        end else if (hit_ctrl) begin
            rd_byte = ctrl_view;
        end else if (hit_stby) begin
            rd_byte = stby_view;
        end
    end

    // Next power mode; hardware standby outranks software standby
    always_comb begin
        mode_nxt = MODE_RUN;
        if (hw_standby) begin
            mode_nxt = MODE_HARD;
        end else if (sw_standby) begin
            mode_nxt = MODE_SOFT;
        end
    end

    // Power mode register; resets to run, so software standby held through reset counts as an entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Code registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel0_code_r <= dac_ctrl_pkg::DATA_RST; // RL2
            channel1_code_r <= dac_ctrl_pkg::DATA_RST; // RL2
        end else if (conv_reinit) begin
            channel0_code_r <= dac_ctrl_pkg::DATA_RST; // RL2
            channel1_code_r <= dac_ctrl_pkg::DATA_RST; // RL2
        end else if (wr_data0) begin
            channel0_code_r <= pwdata[7:0]; // RL1
        end else if (wr_data1) begin
            channel1_code_r <= pwdata[7:0]; // RL1
        end
    end

    // Control register; only bits 7..5 hold state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel1_output_enable_r <= dac_ctrl_pkg::CTRL_RST[dac_ctrl_pkg::CTRL_OE1_BIT]; // RL5
            channel0_output_enable_r <= dac_ctrl_pkg::CTRL_RST[dac_ctrl_pkg::CTRL_OE0_BIT]; // RL5
            joint_conversion_enable_r <= dac_ctrl_pkg::CTRL_RST[dac_ctrl_pkg::CTRL_JOINT_BIT];
        end else if (conv_reinit) begin
            channel1_output_enable_r <= dac_ctrl_pkg::CTRL_RST[dac_ctrl_pkg::CTRL_OE1_BIT]; // RL5
            channel0_output_enable_r <= dac_ctrl_pkg::CTRL_RST[dac_ctrl_pkg::CTRL_OE0_BIT]; // RL5
            joint_conversion_enable_r <= dac_ctrl_pkg::CTRL_RST[dac_ctrl_pkg::CTRL_JOINT_BIT];
        end else if (wr_ctrl) begin
            channel1_output_enable_r <= pwdata[dac_ctrl_pkg::CTRL_OE1_BIT]; // RL6
            channel0_output_enable_r <= pwdata[dac_ctrl_pkg::CTRL_OE0_BIT]; // RL7
            joint_conversion_enable_r <= pwdata[dac_ctrl_pkg::CTRL_JOINT_BIT]; // RL8
        end
    end

    // Standby register survives software standby, not hardware standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_output_enable_r <= dac_ctrl_pkg::STBY_RST[dac_ctrl_pkg::STBY_OE_BIT]; // RL12
        end else if (hw_standby) begin
            standby_output_enable_r <= dac_ctrl_pkg::STBY_RST[dac_ctrl_pkg::STBY_OE_BIT]; // RL12
        end else if (wr_stby) begin
            standby_output_enable_r <= pwdata[dac_ctrl_pkg::STBY_OE_BIT]; // RL13
        end
    end

    // APB answer: ready in the first access cycle, so no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= dac_ctrl_pkg::RDATA_ZERO;
        end else begin
            pready_r <= psel & ~penable;
            pslverr_r <= psel & ~penable & ~hit_any;
            if (psel && !penable && !pwrite) begin
                prdata_r <= {dac_ctrl_pkg::RDATA_PAD, rd_byte};
            end else begin
                prdata_r <= dac_ctrl_pkg::RDATA_ZERO;
            end
        end
    end

    // Converter drive; software standby cuts it unless kept alive, hardware standby always
    always_comb begin
        logic live;
        live = 1'b0;
        live = ~hw_standby & (~sw_standby | standby_output_enable_r); // RL13
        drive_nxt = dac_ctrl_pkg::DRIVE_RST;
        // Codes pass straight through, so a rewrite reaches the macro next cycle
        drive_nxt.channel0_code = channel0_code_r; // RL4 RL14
        drive_nxt.channel1_code = channel1_code_r; // RL4 RL14
        // Joint mode lets either enable start both converters
        drive_nxt.conv_en0 = live & conv_enable(channel0_output_enable_r,
            channel1_output_enable_r, joint_conversion_enable_r); // RL8 RL9
        drive_nxt.conv_en1 = live & conv_enable(channel1_output_enable_r,
            channel0_output_enable_r, joint_conversion_enable_r); // RL8 RL9
        // Output drive ignores the joint bit
        drive_nxt.out_en0 = live & channel0_output_enable_r; // RL7 RL10
        drive_nxt.out_en1 = live & channel1_output_enable_r; // RL6 RL10
    end

    // Registered so the macro sees glitch-free levels, one cycle behind the registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_r <= dac_ctrl_pkg::DRIVE_RST;
        end else begin
            drive_r <= drive_nxt; // RL15
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign drive = drive_r;

endmodule : dual_channel_dac_control
`default_nettype wire

// [rtl/dac_ctrl_pkg.sv]
// Register map, field layout and converter drive bundle for the two-channel DAC control
`default_nettype none
package dac_ctrl_pkg;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [19:0] IDX_DATA0 = 20'hFFF9C;
    localparam logic [19:0] IDX_DATA1 = 20'hFFF9D;
    localparam logic [19:0] IDX_CTRL = 20'hFFF9E;
    localparam logic [19:0] IDX_STBY = 20'hEE01A;
    localparam int IDX_W = 20;
    localparam int ADDR_W = 22;
    localparam int BYTE_LSB = 2;

    // Reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h1F;
    localparam logic [7:0] STBY_RST = 8'hFE;

    // Reserved bits read as one and hold no storage
    localparam logic [7:0] CTRL_RSVD = 8'h1F;
    localparam logic [7:0] STBY_RSVD = 8'hFE;

    // Field positions
    localparam int CTRL_OE1_BIT = 7;
    localparam int CTRL_OE0_BIT = 6;
    localparam int CTRL_JOINT_BIT = 5;
    localparam int STBY_OE_BIT = 0;

    // Bus constants
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    localparam logic [23:0] RDATA_PAD = 24'h00_0000;

    // Drive bundle for the analog converter macro
    typedef struct packed {
        logic [7:0] channel1_code;
        logic [7:0] channel0_code;
        logic conv_en1;
        logic conv_en0;
        logic out_en1;
        logic out_en0;
    } dac_drive_t;

    localparam dac_drive_t DRIVE_RST = '{
        channel1_code: 8'h00, channel0_code: 8'h00,
        conv_en1: 1'b0, conv_en0: 1'b0, out_en1: 1'b0, out_en0: 1'b0};

    // Register index carried in a byte address
    function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[ADDR_W-1:BYTE_LSB];
    endfunction : reg_index
endpackage : dac_ctrl_pkg
`default_nettype wire

// [tb/dac_ctrl_checker.sv]
// Port-level assertions for the two-channel DAC control block
`default_nettype none
module dac_ctrl_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [21:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Power modes and converter drive
    input wire logic sw_standby,
    input wire logic hw_standby,
    input wire dac_ctrl_pkg::dac_drive_t drive
);
    logic [19:0] idx;
    logic [7:0] wdat;
    logic mapped;
    logic rd_ok;
    logic wr0;
    // Decode kept separate from the design's own helper
    assign idx = paddr[21:2];
    assign wdat = pwdata[7:0];
    assign mapped = idx == 20'hFFF9C || idx == 20'hFFF9D || idx == 20'hFFF9E || idx == 20'hEE01A;
    assign rd_ok = psel && penable && pready && !pwrite;
    assign wr0 = psel && penable && pready && pwrite && idx == 20'hFFF9C && !hw_standby;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("error flag disagrees with map");
    chk_ctrl_rsvd: assert property (rd_ok && idx == 20'hFFF9E |-> prdata[4:0] == 5'h1F)
        else $error("reserved control bits not one");
    chk_stby_rsvd: assert property (rd_ok && idx == 20'hEE01A |-> prdata[7:1] == 7'h7F)
        else $error("reserved standby bits not one");
    chk_hw_quiet: assert property ($past(hw_standby) |-> drive[3:0] == 4'h0)
        else $error("drive active in hardware standby");
    chk_out_conv: assert property ((drive[1:0] & ~drive[3:2]) == 2'b00)
        else $error("output enabled without conversion");
    chk_joint_pair: assert property (drive.conv_en0 != drive.conv_en1
        |-> drive.conv_en0 == drive.out_en0 && drive.conv_en1 == drive.out_en1)
        else $error("split conversion not tied to own enable");
    chk_code_follow: assert property (wr0 && !sw_standby
        |=> ##1 drive.channel0_code == $past(wdat, 2))
        else $error("new code not presented");
    // Main scenarios reached
    cover property (pready && pslverr);
    cover property (drive.conv_en1 && !drive.out_en1);
    cover property ($rose(sw_standby));
endmodule : dac_ctrl_checker
bind dual_channel_dac_control dac_ctrl_checker i_dac_ctrl_checker (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_standby(sw_standby), .hw_standby(hw_standby), .drive(drive));
`default_nettype wire

// [tb/dual_channel_dac_control_tb.sv]
// Self-checking bench for the two-channel DAC control block
`default_nettype none
module dual_channel_dac_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [21:0] paddr = 22'h000000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, seed = 32'h0000000E;
    logic pready, pslverr, err, sw_standby = 1'b0, hw_standby = 1'b0;
    dac_ctrl_pkg::dac_drive_t drive;
    int n_errors = 0, checks_done = 0, c0 = 0, c1 = 0, ctl = 8'h1F, stb = 8'hFE;
    logic [19:0] idxs [5] = '{20'hFFF9C, 20'hFFF9D, 20'hFFF9E, 20'hEE01A, 20'h00ABC};
    dual_channel_dac_control i_dual_channel_dac_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sw_standby(sw_standby),
        .hw_standby(hw_standby), .drive(drive));
    // 20 MHz clock
    initial begin
        forever #25 pclk = ~pclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic give_verdict;
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // One APB transfer; upper write lanes carry noise the block must drop
    task automatic apb(input logic w, input logic [19:0] idx, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {seed[31:8], d};
        @(posedge pclk);
        penable <= 1'b1;
        #1;
        for (k = 0; k < 8 && pready !== 1'b1; k++) begin
            @(posedge pclk);
            #1;
        end
        if (k == 8) begin
            n_errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Write with model update; reserved bits always read one
    task automatic wr(input int i, input logic [7:0] d);
        apb(1'b1, idxs[i], d);
        if (i == 0) c0 = d;
        if (i == 1) c1 = d;
        if (i == 2) ctl = d | 8'h1F;
        if (i == 3) stb = d | 8'hFE;
    endtask : wr
    task automatic rall;
        int m [5];
        m = '{c0, c1, ctl, stb, 0};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, idxs[i], 8'h00);
            cmp("prdata", m[i], rd);
            cmp("pslverr", i == 4, err);
        end
    endtask : rall
    task automatic chk_drive;
        logic lv, o1, o0, j;
        repeat (2) @(posedge pclk);
        #1;
        lv = !hw_standby && (!sw_standby || stb[0]);
        o1 = ctl[7];
        o0 = ctl[6];
        j = ctl[5] & (o0 | o1);
        cmp("drive", {c1[7:0], c0[7:0], lv & (o1 | j), lv & (o0 | j), lv & o1, lv & o0},
            drive);
    endtask : chk_drive
    task automatic swsb(input logic on);
        @(posedge pclk);
        sw_standby <= on;
        if (on && !stb[0]) {c0, c1, ctl} = {32'd0, 32'd0, 32'h1F};
    endtask : swsb
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rall();
        // Every enable and joint combination, with random codes
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            wr(0, seed[7:0]);
            wr(1, seed[15:8]);
            wr(2, {i[2:0], seed[20:16]});
            wr(4, seed[7:0]);
            rall();
            chk_drive();
            wr(1, seed[23:16]);
            chk_drive();
        end
        wr(3, 8'h00);
        wr(2, 8'hE0);
        swsb(1'b1);
        chk_drive();
        rall();
        swsb(1'b0);
        wr(0, 8'h5A);
        wr(2, 8'hC0);
        wr(3, 8'hFF);
        swsb(1'b1);
        chk_drive();
        rall();
        swsb(1'b0);
        @(posedge pclk);
        hw_standby <= 1'b1;
        {c0, c1, ctl, stb} = {32'd0, 32'd0, 32'h1F, 32'hFE};
        apb(1'b1, idxs[0], 8'hA5);
        chk_drive();
        rall();
        give_verdict();
    end
endmodule : dual_channel_dac_control_tb
`default_nettype wire
